// file: rtl/wpr_pkg.sv
// Package for the watchdog, power control and reset supervision block.
// Assumes an 8-bit special-register port from the processor core.
package wpr_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_CONTROL    = 8'h87;
  localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'h8F;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_IDLE      = 0;
  localparam int BIT_PDOWN     = 1;
  localparam int BIT_UFLAG0    = 2;
  localparam int BIT_UFLAG1    = 3;
  localparam int BIT_POWER_OFF = 4;
  localparam int BIT_WD_ENABLE = 7;
  localparam int BIT_WD_CLEAR  = 6;
  localparam int BIT_WD_IDLE   = 5;
  localparam int PS_LSB        = 0;
  localparam int PS_MSB        = 2;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [7:0] PORT_RESET     = 8'hFF;
  localparam logic [7:0] STACK_RESET    = 8'h07;
  localparam int         OSC_PER_MCYCLE = 12;
  localparam int         WD_COUNT_BITS  = 14;
  localparam int         PRE_BITS       = 8;
  localparam int         RST_HOLD_MCYC  = 2;

  // Watchdog control fields
  typedef struct packed {
    logic       enable;
    logic       clear;
    logic       idleRun;
    logic       unused;
    logic       spare;
    logic [2:0] prescale;
  } wpr_wdctl_s;

endpackage : wpr_pkg

// file: rtl/wpr_supervisor.sv
// Watchdog, power control and reset supervision for a small controller.
// Assumes ref_clk is the oscillator; registers reached over a plain SFR port.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
module wpr_supervisor import wpr_pkg::*; #(
  parameter int WD_BITS = WD_COUNT_BITS
) (
  // Clock, reset, enable
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       clkEn,
  input  wire logic       powerOnRst,
  // External reset pin and interrupts
  input  wire logic       resetPin,
  input  wire logic       irqPending,
  // Register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // System outputs
  output logic            sysReset,
  output logic            cpuClkEn,
  output logic            periphClkEn,
  output logic            oscRun,
  output logic            wdTimeout,
  output logic      [7:0] portInit,
  output logic      [7:0] stackInit
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Prescale tap: odd ordering of codes 001 and 010 is deliberate
  function automatic logic [PRE_BITS-1:0] preMask(input logic [2:0] ps);
    unique case (ps)
      3'h0: preMask = 8'h01;
      3'h2: preMask = 8'h03;
      3'h1: preMask = 8'h07;
      3'h3: preMask = 8'h0F;
      3'h4: preMask = 8'h1F;
      3'h5: preMask = 8'h3F;
      3'h6: preMask = 8'h7F;
      default: preMask = 8'hFF;
    endcase
  endfunction : preMask

  typedef enum logic [1:0] {
    PM_RUN  = 2'b00,
    PM_IDLE = 2'b01,
    PM_DOWN = 2'b10
  } wpr_pm_e;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic             half_q, half_d;
  logic [3:0]       phase_q, phase_d;
  logic [2:0]       rstCnt_q, rstCnt_d;
  logic             rstHeld_q, rstHeld_d;
  logic             rstSync_q;
  wpr_wdctl_s       wd_q, wd_d;
  logic [PRE_BITS-1:0] pre_q, pre_d;
  logic [WD_BITS-1:0]  cnt_q, cnt_d;
  logic             tmo_q, tmo_d;
  logic [3:0]       pflags_q, pflags_d;
  logic             pof_q, pof_d;
  wpr_pm_e          pm_q, pm_d;
  logic [7:0]       rdata_q, rdata_d;
  logic             mcycEnd;
  logic             state_five_phase_two;
  logic             anyRst;
  logic             wdRun;
  logic             wrWd;

  localparam logic [3:0] PH_LAST  = 4'(OSC_PER_MCYCLE - 1);
  localparam logic [3:0] PH_STATE_FIVE_PHASE_TWO  = 4'(OSC_PER_MCYCLE - 3);
  localparam logic [2:0] HOLD_CNT = 3'(RST_HOLD_MCYC);

  // Internal timing derives from a twelve-phase count per machine cycle
  assign mcycEnd = clkEn && (phase_q == PH_LAST);
  assign state_five_phase_two    = clkEn && (phase_q == PH_STATE_FIVE_PHASE_TWO);
  assign anyRst  = !nrst || rstHeld_q || tmo_q;
  assign wdRun   = wd_q.enable && (pm_q == PM_RUN || (pm_q == PM_IDLE && wd_q.idleRun));
  assign wrWd    = regWr && clkEn && (regAddr == ADDR_WATCHDOG_CONTROL);

  // ----------------------------------------------------------------
  // Timing chain and reset filter
  // ----------------------------------------------------------------
  // Reset pin counted at one sample per machine cycle; a glitch restarts count
  always_comb begin
    half_d    = half_q;
    phase_d   = phase_q;
    rstCnt_d  = rstCnt_q;
    rstHeld_d = rstHeld_q;
    if (clkEn) begin
      half_d  = ~half_q;
      phase_d = (phase_q == PH_LAST) ? 4'h0 : phase_q + 4'h1;
    end
    if (state_five_phase_two) begin
      if (!rstSync_q) begin
        rstCnt_d  = 3'h0;
        rstHeld_d = 1'b0;
      end else if (rstCnt_q < HOLD_CNT) begin
        rstCnt_d = rstCnt_q + 3'h1;
      end
      if (rstSync_q && rstCnt_q + 3'h1 >= HOLD_CNT)
        rstHeld_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      half_q    <= 1'b0;
      phase_q   <= 4'h0;
      rstCnt_q  <= 3'h0;
      rstHeld_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else if (clkEn) begin
      half_q    <= half_d;
      phase_q   <= phase_d;
      rstCnt_q  <= rstCnt_d;
      rstHeld_q <= rstHeld_d;
      if (clkEn)
        rstSync_q <= resetPin;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // Clear bit is acted on at the following machine cycle boundary
  always_comb begin
    wd_d  = wd_q;
    pre_d = pre_q;
    cnt_d = cnt_q;
    tmo_d = 1'b0;
    if (wrWd)
      wd_d = wpr_wdctl_s'(regWdata);
    if (mcycEnd && wd_q.clear) begin
      pre_d    = '0;
      cnt_d    = '0;
      // A clear written in this very cycle must not be lost
      if (!wrWd)
        wd_d.clear = 1'b0;
    end else if (mcycEnd && wdRun) begin
      pre_d = ((pre_q & preMask(wd_q.prescale)) == preMask(wd_q.prescale))
              ? '0 : pre_q + 8'h01;
      if ((pre_q & preMask(wd_q.prescale)) == preMask(wd_q.prescale)) begin
        cnt_d = cnt_q + WD_BITS'(1);
        tmo_d = &cnt_q;
      end
    end
    if (anyRst) begin
      wd_d  = wpr_wdctl_s'(RESET_BYTE);
      pre_d = '0;
      cnt_d = '0;
      tmo_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wd_q  <= wpr_wdctl_s'(RESET_BYTE);
      pre_q <= '0;
      cnt_q <= '0;
      tmo_q <= 1'b0;
    end else if (clkEn) begin
      wd_q  <= wd_d;
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      tmo_q <= tmo_d;
    end
  end

  // ----------------------------------------------------------------
  // Power control and read port
  // ----------------------------------------------------------------
  // Power-off flag survives warm resets; power-on or a write of bit 4 sets it
  always_comb begin
    pflags_d = pflags_q;
    pof_d    = pof_q;
    pm_d     = pm_q;
    rdata_d  = RESET_BYTE;
    if (regWr && clkEn && regAddr == ADDR_POWER_CONTROL) begin
      pflags_d = regWdata[3:0];
      pof_d    = regWdata[BIT_POWER_OFF];
      if (regWdata[BIT_PDOWN])
        pm_d = PM_DOWN;
      else if (regWdata[BIT_IDLE])
        pm_d = PM_IDLE;
    end
    if (pm_q == PM_IDLE && irqPending)
      pm_d = PM_RUN;
    if (pm_d == PM_RUN)
      pflags_d[BIT_IDLE] = 1'b0;
    if (pm_d != PM_DOWN)
      pflags_d[BIT_PDOWN] = 1'b0;
    if (anyRst) begin
      pflags_d = 4'h0;
      pm_d     = PM_RUN;
    end
    if (powerOnRst)
      pof_d = 1'b1;
    if (regRd && clkEn) begin
      if (regAddr == ADDR_POWER_CONTROL)
        rdata_d = {3'h0, pof_q, pflags_q};
      else if (regAddr == ADDR_WATCHDOG_CONTROL)
        rdata_d = wd_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pflags_q <= 4'h0;
      pm_q     <= PM_RUN;
      rdata_q  <= RESET_BYTE;
      pof_q    <= pof_d;
    end else if (clkEn) begin
      pflags_q <= pflags_d;
      pm_q     <= pm_d;
      rdata_q  <= rdata_d;
      pof_q    <= pof_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdata    = rdata_q;
  assign sysReset    = anyRst;
  assign wdTimeout   = tmo_q;
  assign cpuClkEn    = (pm_q == PM_RUN) && half_q;
  assign periphClkEn = (pm_q != PM_DOWN) && half_q;
  assign oscRun      = (pm_q != PM_DOWN);
  assign portInit    = PORT_RESET;
  assign stackInit   = STACK_RESET;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_rstDisable;
    @(posedge ref_clk) disable iff (!nrst) (anyRst && clkEn) |=> !wd_q.enable && cnt_q == '0;
  endproperty
  a_rstDisable: assert property (p_rstDisable) else $error("watchdog not off after reset");

  property p_stopWhenOff;
    @(posedge ref_clk) disable iff (!nrst) !wd_q.enable |=> $stable(cnt_q) || cnt_q == '0;
  endproperty
  a_stopWhenOff: assert property (p_stopWhenOff) else $error("counter moved while off");

  property p_clearWorks;
    @(posedge ref_clk) disable iff (!nrst)
      (mcycEnd && wd_q.clear && !wrWd) |=> pre_q == '0 && cnt_q == '0 && !wd_q.clear;
  endproperty
  a_clearWorks: assert property (p_clearWorks) else $error("clear bit not acted on");

  property p_idleStop;
    @(posedge ref_clk) disable iff (!nrst)
      (pm_q == PM_IDLE && !wd_q.idleRun && !wd_q.clear && !anyRst) |=> $stable(pre_q);
  endproperty
  a_idleStop: assert property (p_idleStop) else $error("watchdog ran in idle");

  property p_tmoReset;
    @(posedge ref_clk) disable iff (!nrst) (tmo_q && clkEn) |-> sysReset ##1 !wd_q.enable;
  endproperty
  a_tmoReset: assert property (p_tmoReset) else $error("time-out gave no reset");

  property p_idleClk;
    @(posedge ref_clk) disable iff (!nrst) pm_q == PM_IDLE |-> !cpuClkEn && oscRun;
  endproperty
  a_idleClk: assert property (p_idleClk) else $error("cpu clock in idle");

  property p_wake;
    @(posedge ref_clk) disable iff (!nrst)
      (clkEn && pm_q == PM_IDLE && irqPending) |=> pm_q == PM_RUN;
  endproperty
  a_wake: assert property (p_wake) else $error("idle not left on interrupt");

  property p_down;
    @(posedge ref_clk) disable iff (!nrst) pm_q == PM_DOWN |-> !oscRun && !periphClkEn;
  endproperty
  a_down: assert property (p_down) else $error("clock in power-down");

  property p_pofKeep;
    @(posedge ref_clk) disable iff (!nrst)
      (!powerOnRst && !(regWr && regAddr == ADDR_POWER_CONTROL)) |=> $stable(pof_q);
  endproperty
  a_pofKeep: assert property (p_pofKeep) else $error("power-off flag changed");

  c_timeout: cover property (@(posedge ref_clk) disable iff (!nrst) tmo_q);
  c_idleWake: cover property (@(posedge ref_clk) disable iff (!nrst) pm_q == PM_IDLE ##1 pm_q == PM_RUN);
  c_pinReset: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(rstHeld_q));

endmodule : wpr_supervisor

// file: tb/test_wpr_supervisor.sv
// Self-checking bench for the supervisor, driving it through the core model.
// Assumes WD_BITS of 4 so a time-out takes prescale times 192 clocks.
`timescale 1ns/1ns
module test_wpr_supervisor import wpr_pkg::*;;
  logic       ref_clk, nrst, clkEn, powerOnRst, resetPin, irqPending;
  logic       regWr, regRd, sysReset, cpuClkEn, periphClkEn, oscRun, wdTimeout;
  logic [7:0] regAddr, regWdata, regRdata, portInit, stackInit, d;
  int         num_errors, checks_done, nTo, nRst, nCpu, nPer, n;
  int         divTab [8] = '{2, 8, 4, 16, 32, 64, 128, 256};
  localparam logic [7:0] PC = ADDR_POWER_CONTROL;
  localparam logic [7:0] WC = ADDR_WATCHDOG_CONTROL;
  localparam int         MC = 192;  // 2^4 machine cycles of 12 clocks

  // ----------------------------------------
  // Instances, clock, monitors
  // ----------------------------------------
  wpr_supervisor #(.WD_BITS(4)) i_wpr_supervisor (.ref_clk, .nrst, .clkEn, .powerOnRst,
    .resetPin, .irqPending, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .sysReset,
    .cpuClkEn, .periphClkEn, .oscRun, .wdTimeout, .portInit, .stackInit);
  wpr_core_model i_wpr_core_model (.ref_clk, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .irqPending);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Event counters, cleared on the falling edge to avoid races
  always @(posedge ref_clk) begin
    nTo  <= nTo + int'(wdTimeout === 1'b1);
    nRst <= nRst + int'(sysReset === 1'b1);
    nCpu <= nCpu + int'(cpuClkEn === 1'b1);
    nPer <= nPer + int'(periphClkEn === 1'b1);
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
    i_wpr_core_model.rd(a, d);
    chk(nm, {8'h00, d}, {8'h00, e});
  endtask : rdc

  // Clear the event counters, then let k cycles run; ends on a settled edge
  task automatic zero(input int k);
    @(negedge ref_clk);
    {nTo, nRst, nCpu, nPer} = '0;
    repeat (k) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : zero

  task automatic pulseRst();
    @(posedge ref_clk);
    nrst <= 1'b0;
    @(posedge ref_clk);
    nrst <= 1'b1;
  endtask : pulseRst

  // Enable with a prescale code and time the overflow
  task automatic tmo(input logic [7:0] v, input int div);
    zero(0);
    i_wpr_core_model.wr(WC, v);
    n = 0;
    while (nTo == 0 && n < div * MC + 48) begin
      @(negedge ref_clk);
      n++;
    end
    chk("timeout_window", 16'(n >= div * MC - 24 && n <= div * MC + 24), 16'h1);
    chk("timeout_reset", 16'(nRst > 0), 16'h1);
    rdc(WC, 8'h00, "wdctl_after_timeout");
  endtask : tmo

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard, well beyond the expected run
  initial begin
    #1600000;
    num_errors++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {nrst, resetPin} = 2'b00;
    {clkEn, powerOnRst} = 2'b11;
    {nTo, nRst, nCpu, nPer} = '0;
    repeat (4) @(posedge ref_clk);
    nrst       <= 1'b1;
    powerOnRst <= 1'b0;
    rdc(PC, 8'h10, "pctl_reset");
    rdc(WC, 8'h00, "wdctl_reset");
    chk("port_init", {8'h00, portInit}, 16'h00FF);
    chk("stack_init", {8'h00, stackInit}, 16'h0007);
    i_wpr_core_model.wr(8'h8E, 8'hFF);
    rdc(8'h8E, 8'h00, "unmapped");
    rdc(WC, 8'h00, "wdctl_unmapped_write");
    pulseRst();
    rdc(PC, 8'h10, "pof_survives");
    i_wpr_core_model.wr(PC, 8'h0C);
    rdc(PC, 8'h0C, "user_flags");
    pulseRst();
    rdc(PC, 8'h00, "flags_after_reset");
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      i_wpr_core_model.wr(WC, 8'(i));
      rdc(WC, 8'(i), "prescale_code");
    end
    for (int i = 0; i < 5; i++) tmo(8'h80 | 8'(i), divTab[i]);
    $display("test prescale done");
    zero(0);
    i_wpr_core_model.wr(WC, 8'h00);
    zero(600);
    chk("disabled_quiet", 16'(nTo), 16'h0);
    i_wpr_core_model.wr(WC, 8'hC0);
    clkEn <= 1'b0;
    zero(500);
    chk("frozen_quiet", 16'(nTo), 16'h0);
    @(posedge ref_clk);
    clkEn <= 1'b1;
    i_wpr_core_model.wr(WC, 8'h80);
    repeat (6) begin
      repeat (250) @(posedge ref_clk);
      i_wpr_core_model.wr(WC, 8'hC0);
    end
    chk("cleared_quiet", 16'(nTo), 16'h0);
    repeat (OSC_PER_MCYCLE) @(posedge ref_clk);
    rdc(WC, 8'h80, "clear_self_clears");
    tmo(8'h80, 2);
    $display("test clear done");
    i_wpr_core_model.wr(WC, 8'h80);
    i_wpr_core_model.wr(PC, 8'h01);
    zero(2);
    zero(500);
    chk("idle_cpu_stopped", 16'(nCpu), 16'h0);
    chk("idle_periph_runs", 16'(nPer > 0), 16'h1);
    chk("idle_wd_stopped", 16'(nTo), 16'h0);
    i_wpr_core_model.wake(30);
    zero(0);
    i_wpr_core_model.wr(WC, 8'h00);
    rdc(PC, 8'h00, "idle_bit_cleared");
    chk("wake_cpu_runs", 16'(nCpu > 0), 16'h1);
    i_wpr_core_model.wr(PC, 8'h01);
    tmo(8'hE0, 2);
    zero(4);
    chk("reset_ends_idle", 16'(nCpu > 0), 16'h1);
    $display("test idle done");
    i_wpr_core_model.wr(PC, 8'h03);
    zero(3);
    i_wpr_core_model.wake(30);
    zero(48);
    chk("pdown_osc", {15'h0, oscRun}, 16'h0);
    chk("pdown_clocks", 16'(nPer + nCpu), 16'h0);
    pulseRst();
    zero(2);
    chk("pdown_reset_exit", {15'h0, oscRun}, 16'h1);
    rdc(PC, 8'h00, "pdown_cleared");
    $display("test power-down done");
    i_wpr_core_model.wr(WC, 8'h80);
    zero(0);
    @(posedge ref_clk);
    resetPin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    resetPin <= 1'b0;
    repeat (30) @(negedge ref_clk);
    chk("glitch_ignored", 16'(nRst), 16'h0);
    rdc(WC, 8'h80, "glitch_keeps_wd");
    @(posedge ref_clk);
    resetPin <= 1'b1;
    repeat (36) @(posedge ref_clk);
    resetPin <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk("pin_reset", 16'(nRst > 0), 16'h1);
    rdc(WC, 8'h00, "pin_reset_wd_off");
    $display("test reset pin done");
    tally_and_finish();
  end
endmodule : test_wpr_supervisor

// file: tb/wpr_core_model.sv
// Processor core model: master of the special-register port, source of wake requests.
// Assumes the supervisor takes strobes on the rising edge of ref_clk.
`timescale 1ns/1ns
module wpr_core_model (
  // Clock
  input  wire logic       ref_clk,
  // Register port
  output logic      [7:0] regAddr,
  output logic      [7:0] regWdata,
  output logic            regWr,
  output logic            regRd,
  input  wire logic [7:0] regRdata,
  // Wake request
  output logic            irqPending
);
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  initial begin
    regAddr    = 8'h00;
    regWdata   = 8'h00;
    regWr      = 1'b0;
    regRd      = 1'b0;
    irqPending = 1'b0;
  end

  // One-cycle write strobe; the slave never stalls
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge ref_clk);
    regWr    <= 1'b0;
    regWdata <= ~v;  // Stale data never looks valid
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd   <= 1'b0;
    #1 v = regRdata;
  endtask : rd

  // Level wake request held for k cycles
  task automatic wake(input int k);
    @(posedge ref_clk);
    irqPending <= 1'b1;
    repeat (k) @(posedge ref_clk);
    irqPending <= 1'b0;
  endtask : wake
endmodule : wpr_core_model
